// >>> src/wsml_top.sv
/*
 * wsml_top: warning detection, masking, latching and selection onto
 * two warning outputs, plus the simple servo status outputs.
 * Assumes condition inputs are synchronous to CLK_SYS (25 MHz) and
 * that configuration inputs are held steady by the host side.
 */
// Function
// - overload warning at load factor of 85 percent or more; code 1, mask bit7
// - regeneration warning at regenerative load 85 percent or more; code 2, bit5
// - battery warning at 3.2 V or lower; code 3, mask bit0
// - fan warning after fan stopped one second; code 4, mask bit6
// - encoder comm warning when consecutive errors exceed limit; code 5, bit4
// - encoder overheat warning while encoder reports heat; code 6, bit3
// - oscillation warning when vibration detected; code 7, mask bit9
// - lifetime warning when remaining life below limit; code 8, bit2
// - scale error warning on feedback scale alarm; code 9, bit8
// - scale comm warning when consecutive errors exceed limit; code 10, bit10
// - deterioration warning at constant speed outside range; code 22, bit7
// - deterioration warning disabled when expansion setting bit1 is zero
// - mains-off warning past set time, only for 10 to 1999; code 14, bit14
// - warnings held 1 to 10 s or unlimited; battery, lifetime always unlimited
// - selection zero gives OR of all warnings, else matching warning only
// - mask bit set to one suppresses that warning
// - position command output active while position command applied
// - speed-limited output active while torque control limits speed
// - clearable-alarm output active when active alarm is clearable
// - speed command output active while speed command applied in speed control
// - servo-on output active while servo is on
// - warning output on while selected warning, or any in OR mode
`timescale 1ns/100ps
`default_nettype none

module wsml_top
   import wsml_pkg::*;
#(
   parameter int SEC_CYC  = SEC_CYCLES,      // cycles per latch second
   parameter int FAN_CYC  = FAN_STOP_CYCLES, // fan stop time in cycles
   parameter int MS_CYC   = MS_CYCLES        // cycles per millisecond
)
(
   input  wire logic        CLK_SYS,         // system clock, 25 MHz
   input  wire logic        RST_B,           // sync reset, active low
   // measured conditions
   input  wire logic [7:0]  LOAD_PCT,        // load factor, percent
   input  wire logic [7:0]  REGEN_PCT,       // regen load factor, percent
   input  wire logic [11:0] BATT_MV,         // battery voltage, mV
   input  wire logic        FAN_STOPPED,     // fan not turning
   input  wire logic        ENC_COMM_ERR,    // encoder frame error pulse
   input  wire logic        ENC_COMM_OK,     // encoder frame good pulse
   input  wire logic [7:0]  ENC_ERR_LIMIT,   // allowed consecutive errors
   input  wire logic        ENC_HOT,         // encoder overheat report
   input  wire logic        OSC_DETECT,      // vibration detected
   input  wire logic [15:0] LIFE_LEFT,       // remaining life
   input  wire logic [15:0] LIFE_LIMIT,      // life warning threshold
   input  wire logic        SCL_ALARM,       // feedback scale alarm
   input  wire logic        SCL_COMM_ERR,    // scale frame error pulse
   input  wire logic        SCL_COMM_OK,     // scale frame good pulse
   input  wire logic [7:0]  SCL_ERR_LIMIT,   // allowed consecutive errors
   input  wire logic        CONST_SPEED,     // running at constant speed
   input  wire logic        EST_OUT_RANGE,   // load estimate out of range
   input  wire logic        TRQ_OUT_RANGE,   // torque command out of range
   input  wire logic        MAINS_PRESENT,   // main power present
   // configuration
   input  wire logic [3:0]  WARNING_LATCH_TIME,     // 1..10 s, else unlimited
   input  wire logic [7:0]  WARNING_SELECT_ONE,     // code for output one
   input  wire logic [7:0]  WARNING_SELECT_TWO,     // code for output two
   input  wire logic [15:0] WARNING_MASK,           // 1 masks a warning
   input  wire logic [15:0] FUNCTION_EXPANSION_THREE, // bit1 enables diag
   input  wire logic [10:0] MAINS_LOSS_DETECT_TIME, // ms
   input  wire logic        WARNING_CLEAR,   // releases unlimited holds
   // servo state
   input  wire logic        POS_CMD_IN,      // position command applied
   input  wire logic        TORQUE_MODE,     // torque control active
   input  wire logic        SPEED_LIMIT_IN,  // speed limit engaged
   input  wire logic        ALARM_ACTIVE,    // an alarm is active
   input  wire logic        ALARM_CLEARABLE, // that alarm can be cleared
   input  wire logic        SPEED_MODE,      // speed control active
   input  wire logic        SPEED_CMD_IN,    // speed command applied
   input  wire logic        SERVO_ON_IN,     // servo is on
   // outputs
   output logic             WARNING_OUT_ONE,     // selected warning one
   output logic             WARNING_OUT_TWO,     // selected warning two
   output logic             POS_CMD_OUT,         // position command on
   output logic             SPEED_LIMITED,       // speed in limit
   output logic             CLEARABLE_ALARM_FLAG, // clearable alarm
   output logic             SPEED_CMD_OUT,       // speed command on
   output logic             SERVO_ON_STATUS      // servo on
);

   wsml_top_s q;
   wsml_top_s d;

   logic [NUM_WARN-1:0] masked;
   logic [NUM_WARN-1:0] held;
   logic [NUM_WARN-1:0] unlimited;
   logic                latch_ok;
   logic                mains_ok;
   logic [NUM_WARN-1:0] cond;

   // latch time outside 1..10 means hold without limit
   assign latch_ok = (WARNING_LATCH_TIME >= LATCH_MIN_S) &&
                     (WARNING_LATCH_TIME <= LATCH_MAX_S);

   // mains detection only armed for a legal time setting
   assign mains_ok = (MAINS_LOSS_DETECT_TIME >= MAINS_TIME_MIN) &&
                     (MAINS_LOSS_DETECT_TIME <= MAINS_TIME_MAX);

   // raw conditions, computed combinationally and registered in q.raw
   always_comb begin
      cond = '0;
      cond[W_OVERLOAD] = LOAD_PCT >= LOAD_WARN_PCT;
      cond[W_REGEN]    = REGEN_PCT >= LOAD_WARN_PCT;
      cond[W_BATTERY]  = BATT_MV <= BATT_WARN_MV;
      cond[W_FAN]      = q.fan_cnt >= 25'(FAN_CYC);
      cond[W_ENC_COMM] = q.enc_err_cnt > ENC_ERR_LIMIT;
      cond[W_ENC_HEAT] = ENC_HOT;
      cond[W_OSCILL]   = OSC_DETECT;
      cond[W_LIFETIME] = LIFE_LEFT < LIFE_LIMIT;
      cond[W_SCL_ERR]  = SCL_ALARM;
      cond[W_SCL_COMM] = q.scl_err_cnt > SCL_ERR_LIMIT;
      // only judged at constant speed, and only when enabled
      cond[W_DETERIOR] = CONST_SPEED &&
                         (EST_OUT_RANGE || TRQ_OUT_RANGE) &&
                         FUNCTION_EXPANSION_THREE[FUNC_EXP_DIAG_BIT];
      cond[W_MAINS]    = mains_ok &&
                         (q.mains_ms > MAINS_LOSS_DETECT_TIME);
   end

   // per-slot mask, hold mode and latch instance
   genvar gi;
   generate
      for (gi = 0; gi < NUM_WARN; gi++) begin : g_warn
         // a masked warning never reaches the latch
         assign masked[gi] = q.raw[gi] && !WARNING_MASK[wsml_mask_bit(gi)];
         // battery and lifetime ignore the latch time setting
         assign unlimited[gi] = !latch_ok ||
                                (gi == W_BATTERY) ||
                                (gi == W_LIFETIME);
         wsml_latch u_latch (
            .clk      (CLK_SYS),
            .rst_b    (RST_B),
            .cond     (masked[gi]),
            .no_limit (unlimited[gi]),
            .latch_s  (WARNING_LATCH_TIME),
            .sec_tick (q.sec_tick),
            .clear    (WARNING_CLEAR),
            .held     (held[gi])
         );
      end
   endgenerate

   // next-state logic for counters, raw flags and outputs
   always_comb begin
      logic any;
      logic hit_one;
      logic hit_two;
      any     = 1'b0;
      hit_one = 1'b0;
      hit_two = 1'b0;
      d       = q;

      // seconds tick for the latch timers
      d.sec_tick = 1'b0;
      if (q.sec_div >= 25'(SEC_CYC - 1)) begin
         d.sec_div  = '0;
         d.sec_tick = 1'b1;
      end else begin
         d.sec_div = q.sec_div + 25'h1;
      end

      // millisecond tick for mains loss timing
      d.ms_tick = 1'b0;
      if (q.ms_div >= 15'(MS_CYC - 1)) begin
         d.ms_div  = '0;
         d.ms_tick = 1'b1;
      end else begin
         d.ms_div = q.ms_div + 15'h1;
      end

      // fan must stay stopped without a break; saturate
      if (!FAN_STOPPED) begin
         d.fan_cnt = '0;
      end else if (q.fan_cnt < 25'(FAN_CYC)) begin
         d.fan_cnt = q.fan_cnt + 25'h1;
      end

      // consecutive encoder errors; any good frame restarts
      if (ENC_COMM_OK) begin
         d.enc_err_cnt = '0;
      end else if (ENC_COMM_ERR && q.enc_err_cnt != 8'hFF) begin
         d.enc_err_cnt = q.enc_err_cnt + 8'h1;
      end

      // consecutive scale errors, same scheme
      if (SCL_COMM_OK) begin
         d.scl_err_cnt = '0;
      end else if (SCL_COMM_ERR && q.scl_err_cnt != 8'hFF) begin
         d.scl_err_cnt = q.scl_err_cnt + 8'h1;
      end

      // mains interruption length in ms; saturate past the max
      if (MAINS_PRESENT) begin
         d.mains_ms = '0;
      end else if (q.ms_tick && q.mains_ms != 11'h7FF) begin
         d.mains_ms = q.mains_ms + 11'h1;
      end

      d.raw = cond;

      // selection sees only masked and latched warnings
      for (int i = 0; i < NUM_WARN; i++) begin
         any = any | held[i];
         if (wsml_code(i) == WARNING_SELECT_ONE) begin
            hit_one = hit_one | held[i];
         end
         if (wsml_code(i) == WARNING_SELECT_TWO) begin
            hit_two = hit_two | held[i];
         end
      end

      // zero means OR of all; unlisted codes match nothing
      d.warn_one = (WARNING_SELECT_ONE == SEL_ALL) ? any : hit_one;
      d.warn_two = (WARNING_SELECT_TWO == SEL_ALL) ? any : hit_two;

      // status outputs, registered for a clean pin drive
      d.pos_cmd = POS_CMD_IN;
      d.spd_lim = TORQUE_MODE && SPEED_LIMIT_IN;
      d.clr_alm = ALARM_ACTIVE && ALARM_CLEARABLE;
      d.spd_cmd = SPEED_MODE && SPEED_CMD_IN;
      d.srv_on  = SERVO_ON_IN;
   end

   // one register for all state except the per-slot latches
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign WARNING_OUT_ONE      = q.warn_one;
   assign WARNING_OUT_TWO      = q.warn_two;
   assign POS_CMD_OUT          = q.pos_cmd;
   assign SPEED_LIMITED        = q.spd_lim;
   assign CLEARABLE_ALARM_FLAG = q.clr_alm;
   assign SPEED_CMD_OUT        = q.spd_cmd;
   assign SERVO_ON_STATUS      = q.srv_on;

endmodule

`default_nettype wire

// >>> include/wsml_pkg.sv
/*
 * wsml_pkg: constants, warning table and state types for the warning
 * select, mask and latch block of a servo driver.
 * Assumes one 25 MHz system clock; nothing else is shared.
 */
package wsml_pkg;

   // clock and timing
   localparam int CLK_HZ           = 25_000_000;
   localparam int FAN_STOP_TIME_MS = 1000;
   localparam int LATCH_TICK_MS    = 1000;
   localparam int MS_PER_S         = 1000;
   localparam int SEC_CYCLES       = CLK_HZ / MS_PER_S * LATCH_TICK_MS;
   localparam int FAN_STOP_CYCLES  = CLK_HZ / MS_PER_S * FAN_STOP_TIME_MS;
   localparam int MS_CYCLES        = CLK_HZ / MS_PER_S;

   // detection thresholds
   localparam logic [7:0]  LOAD_WARN_PCT   = 8'h55;    // 85 percent
   localparam logic [11:0] BATT_WARN_MV    = 12'hC80;  // 3200 mV
   localparam logic [10:0] MAINS_TIME_MIN  = 11'h00A;  // 10 ms
   localparam logic [10:0] MAINS_TIME_MAX  = 11'h7CF;  // 1999 ms
   localparam logic [3:0]  LATCH_MIN_S     = 4'h1;
   localparam logic [3:0]  LATCH_MAX_S     = 4'hA;
   localparam int          FUNC_EXP_DIAG_BIT = 1;
   localparam logic [7:0]  SEL_ALL         = 8'h00;

   // warning slots
   localparam int NUM_WARN   = 12;
   localparam int W_OVERLOAD = 0;
   localparam int W_REGEN    = 1;
   localparam int W_BATTERY  = 2;
   localparam int W_FAN      = 3;
   localparam int W_ENC_COMM = 4;
   localparam int W_ENC_HEAT = 5;
   localparam int W_OSCILL   = 6;
   localparam int W_LIFETIME = 7;
   localparam int W_SCL_ERR  = 8;
   localparam int W_SCL_COMM = 9;
   localparam int W_DETERIOR = 10;
   localparam int W_MAINS    = 11;

   // output selection code of each slot
   function automatic logic [7:0] wsml_code(input int idx);
      unique case (idx)
         W_OVERLOAD: wsml_code = 8'h01;
         W_REGEN:    wsml_code = 8'h02;
         W_BATTERY:  wsml_code = 8'h03;
         W_FAN:      wsml_code = 8'h04;
         W_ENC_COMM: wsml_code = 8'h05;
         W_ENC_HEAT: wsml_code = 8'h06;
         W_OSCILL:   wsml_code = 8'h07;
         W_LIFETIME: wsml_code = 8'h08;
         W_SCL_ERR:  wsml_code = 8'h09;
         W_SCL_COMM: wsml_code = 8'h0A;
         W_DETERIOR: wsml_code = 8'h16;
         default:    wsml_code = 8'h0E;
      endcase
   endfunction

   // mask bit of each slot; overload and deterioration share one bit
   function automatic int wsml_mask_bit(input int idx);
      unique case (idx)
         W_OVERLOAD: wsml_mask_bit = 7;
         W_REGEN:    wsml_mask_bit = 5;
         W_BATTERY:  wsml_mask_bit = 0;
         W_FAN:      wsml_mask_bit = 6;
         W_ENC_COMM: wsml_mask_bit = 4;
         W_ENC_HEAT: wsml_mask_bit = 3;
         W_OSCILL:   wsml_mask_bit = 9;
         W_LIFETIME: wsml_mask_bit = 2;
         W_SCL_ERR:  wsml_mask_bit = 8;
         W_SCL_COMM: wsml_mask_bit = 10;
         W_DETERIOR: wsml_mask_bit = 7;
         default:    wsml_mask_bit = 14;
      endcase
   endfunction

   typedef struct packed {
      logic       held;
      logic [3:0] secs_left;
   } wsml_latch_s;

   typedef struct packed {
      logic [24:0]         sec_div;
      logic                sec_tick;
      logic [14:0]         ms_div;
      logic                ms_tick;
      logic [24:0]         fan_cnt;
      logic [7:0]          enc_err_cnt;
      logic [7:0]          scl_err_cnt;
      logic [10:0]         mains_ms;
      logic [NUM_WARN-1:0] raw;
      logic                warn_one;
      logic                warn_two;
      logic                pos_cmd;
      logic                spd_lim;
      logic                clr_alm;
      logic                spd_cmd;
      logic                srv_on;
   } wsml_top_s;

endpackage

// >>> src/wsml_latch.sv
/*
 * wsml_latch: holds one masked warning for a number of seconds after
 * its condition goes away, or until cleared in no-limit mode.
 * Assumes a one-cycle seconds tick from the parent and a synchronous,
 * active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none

module wsml_latch
   import wsml_pkg::*;
(
   input  wire logic       clk,       // system clock
   input  wire logic       rst_b,     // sync reset, active low
   input  wire logic       cond,      // masked warning condition
   input  wire logic       no_limit,  // hold until cleared
   input  wire logic [3:0] latch_s,   // hold time in seconds
   input  wire logic       sec_tick,  // one pulse per second
   input  wire logic       clear,     // releases a no-limit hold
   output logic            held       // latched warning
);

   wsml_latch_s q;
   wsml_latch_s d;

   // condition reloads the timer; set wins over clear and expiry
   always_comb begin
      d = q;
      if (cond) begin
         d.held      = 1'b1;
         d.secs_left = latch_s;
      end else if (q.held) begin
         if (no_limit) begin
            if (clear) begin
               d.held = 1'b0;
            end
         end else if (sec_tick) begin
            // waits out the partial second too, so never short
            if (q.secs_left == 4'h0) begin
               d.held = 1'b0;
            end else begin
               d.secs_left = q.secs_left - 4'h1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign held = q.held;

endmodule

`default_nettype wire

// >>> sim/wsml_host_model.sv
/*
 * wsml_host_model: host side that picks the two warning output codes.
 * Assumes index 0 means OR of all warnings and 1..12 the listed slots.
 */
`timescale 1ns/100ps
`default_nettype none

module wsml_host_model
   import wsml_pkg::*;
(
   input  wire logic [3:0] idx_one, // choice for output one
   input  wire logic [3:0] idx_two, // choice for output two
   output logic      [7:0] sel_one, // code to output one
   output logic      [7:0] sel_two  // code to output two
);
   localparam logic [7:0] code_tbl [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                                           8'h07, 8'h08, 8'h09, 8'h0A, 8'h16, 8'h0E};

   // only zero or listed codes ever leave the host, even for a bad index
   assign sel_one = (idx_one < 4'hD) ? code_tbl[idx_one] : SEL_ALL;
   assign sel_two = (idx_two < 4'hD) ? code_tbl[idx_two] : SEL_ALL;
endmodule
`default_nettype wire

// >>> sim/wsml_top_props.sv
/*
 * wsml_top_props: port-level assertions on wsml_top.
 * Assumes one clock and the synchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none

module wsml_top_props
   import wsml_pkg::*;
(
   input wire logic        CLK_SYS,              // clock
   input wire logic        RST_B,                // reset
   input wire logic        POS_CMD_IN,           // status in
   input wire logic        TORQUE_MODE,          // status in
   input wire logic        SPEED_LIMIT_IN,       // status in
   input wire logic        ALARM_ACTIVE,         // status in
   input wire logic        ALARM_CLEARABLE,      // status in
   input wire logic        SPEED_MODE,           // status in
   input wire logic        SPEED_CMD_IN,         // status in
   input wire logic        SERVO_ON_IN,          // status in
   input wire logic        POS_CMD_OUT,          // status out
   input wire logic        SPEED_LIMITED,        // status out
   input wire logic        CLEARABLE_ALARM_FLAG, // status out
   input wire logic        SPEED_CMD_OUT,        // status out
   input wire logic        SERVO_ON_STATUS,      // status out
   input wire logic [7:0]  LOAD_PCT,             // load
   input wire logic [7:0]  REGEN_PCT,            // regen load
   input wire logic [15:0] WARNING_MASK,         // mask
   input wire logic [7:0]  WARNING_SELECT_ONE,   // select one
   input wire logic [7:0]  WARNING_SELECT_TWO,   // select two
   input wire logic        WARNING_OUT_ONE,      // warning one
   input wire logic        WARNING_OUT_TWO       // warning two
);
   logic [1:0] up_q;

   // edges since release; $past would otherwise see reset-time inputs
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) up_q <= 2'h0;
      else if (up_q != 2'h3) up_q <= up_q + 2'h1;
   end
   wire logic run = (up_q == 2'h3);

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);

   sequence s_over;
      LOAD_PCT >= LOAD_WARN_PCT && !WARNING_MASK[7] && WARNING_SELECT_ONE == 8'h01;
   endsequence

   a_pos_follow:
   assert property (run |-> POS_CMD_OUT == $past(POS_CMD_IN)) else $error("position command out wrong");
   a_speed_lim_follow:
   assert property (run |-> SPEED_LIMITED == $past(TORQUE_MODE && SPEED_LIMIT_IN)) else $error("speed limited wrong");
   a_clr_alarm_follow:
   assert property (run |-> CLEARABLE_ALARM_FLAG == $past(ALARM_ACTIVE && ALARM_CLEARABLE))
      else $error("clearable alarm flag wrong");
   a_spd_cmd_follow:
   assert property (run |-> SPEED_CMD_OUT == $past(SPEED_MODE && SPEED_CMD_IN)) else $error("speed command wrong");
   a_servo_on_follow:
   assert property (run && $changed(SERVO_ON_IN) |=> SERVO_ON_STATUS == $past(SERVO_ON_IN))
      else $error("servo on status wrong");
   a_overload_warn:
   assert property (run ##0 s_over [*4] |=> WARNING_OUT_ONE) else $error("overload warning missing");
   a_regen_warn:
   assert property (run ##0 (REGEN_PCT >= LOAD_WARN_PCT && !WARNING_MASK[5] && WARNING_SELECT_ONE == 8'h02) [*4]
                    |=> WARNING_OUT_ONE) else $error("regen warning missing");
   a_or_both_same:
   assert property ((WARNING_SELECT_ONE == SEL_ALL && WARNING_SELECT_TWO == SEL_ALL) [*4]
                    |-> WARNING_OUT_ONE == WARNING_OUT_TWO) else $error("or mode outputs differ");

   // main scenarios
   c_deter_seen: cover property (WARNING_OUT_ONE && WARNING_SELECT_ONE == 8'h16);
   c_or_seen: cover property (WARNING_OUT_TWO && WARNING_SELECT_TWO == SEL_ALL);
   c_release_seen: cover property ($fell(WARNING_OUT_ONE));
endmodule

bind wsml_top wsml_top_props u_props (
   .CLK_SYS(CLK_SYS), .RST_B(RST_B), .POS_CMD_IN(POS_CMD_IN), .TORQUE_MODE(TORQUE_MODE),
   .SPEED_LIMIT_IN(SPEED_LIMIT_IN), .ALARM_ACTIVE(ALARM_ACTIVE), .ALARM_CLEARABLE(ALARM_CLEARABLE),
   .SPEED_MODE(SPEED_MODE), .SPEED_CMD_IN(SPEED_CMD_IN), .SERVO_ON_IN(SERVO_ON_IN),
   .POS_CMD_OUT(POS_CMD_OUT), .SPEED_LIMITED(SPEED_LIMITED), .CLEARABLE_ALARM_FLAG(CLEARABLE_ALARM_FLAG),
   .SPEED_CMD_OUT(SPEED_CMD_OUT), .SERVO_ON_STATUS(SERVO_ON_STATUS), .LOAD_PCT(LOAD_PCT),
   .REGEN_PCT(REGEN_PCT), .WARNING_MASK(WARNING_MASK), .WARNING_SELECT_ONE(WARNING_SELECT_ONE),
   .WARNING_SELECT_TWO(WARNING_SELECT_TWO), .WARNING_OUT_ONE(WARNING_OUT_ONE), .WARNING_OUT_TWO(WARNING_OUT_TWO)
);
`default_nettype wire

// >>> sim/wsml_top_tb_top.sv
/*
 * wsml_top_tb_top: self-checking bench for wsml_top with short time params.
 * Assumes the host model for select codes and the bound checker.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); end end

module wsml_top_tb_top
   import wsml_pkg::*;
;
   localparam int SC = 20, FC = 30, MC = 4;
   localparam int mbit [12] = '{7, 5, 0, 6, 4, 3, 9, 2, 8, 10, 7, 14};
   logic clk = 1'b0, rst_b = 1'b0, fan = 1'b0, enc_err = 1'b0, enc_ok = 1'b0, enc_hot = 1'b0;
   logic osc = 1'b0, scl_alm = 1'b0, scl_err = 1'b0, scl_ok = 1'b0, cspd = 1'b0, est = 1'b0;
   logic trq = 1'b0, mains = 1'b1, wclr = 1'b0, o1, o2, pco, sl, caf, sco, sos;
   logic [7:0] load_pct = 8'h00, regen_pct = 8'h00, srv = 8'h00, s1, s2;
   logic [11:0] batt_mv = BATT_WARN_MV + 12'h001;
   logic [15:0] life_left = 16'h0100, mask = 16'h0000, fexp = 16'h0002;
   logic [3:0] ltime = 4'h1, i1 = 4'h0, i2 = 4'h0;
   logic [10:0] mtime = MAINS_TIME_MIN;
   int err_count = 0, n_compared = 0;

   always #20 clk = ~clk;

   wsml_host_model u_host (.idx_one(i1), .idx_two(i2), .sel_one(s1), .sel_two(s2));

   wsml_top #(.SEC_CYC(SC), .FAN_CYC(FC), .MS_CYC(MC)) u_dut (
      .CLK_SYS(clk), .RST_B(rst_b), .LOAD_PCT(load_pct), .REGEN_PCT(regen_pct), .BATT_MV(batt_mv),
      .FAN_STOPPED(fan), .ENC_COMM_ERR(enc_err), .ENC_COMM_OK(enc_ok), .ENC_ERR_LIMIT(8'h03),
      .ENC_HOT(enc_hot), .OSC_DETECT(osc), .LIFE_LEFT(life_left), .LIFE_LIMIT(16'h0100),
      .SCL_ALARM(scl_alm), .SCL_COMM_ERR(scl_err), .SCL_COMM_OK(scl_ok), .SCL_ERR_LIMIT(8'h03),
      .CONST_SPEED(cspd), .EST_OUT_RANGE(est), .TRQ_OUT_RANGE(trq), .MAINS_PRESENT(mains),
      .WARNING_LATCH_TIME(ltime), .WARNING_SELECT_ONE(s1), .WARNING_SELECT_TWO(s2),
      .WARNING_MASK(mask), .FUNCTION_EXPANSION_THREE(fexp), .MAINS_LOSS_DETECT_TIME(mtime),
      .WARNING_CLEAR(wclr), .POS_CMD_IN(srv[0]), .TORQUE_MODE(srv[1]), .SPEED_LIMIT_IN(srv[2]),
      .ALARM_ACTIVE(srv[3]), .ALARM_CLEARABLE(srv[4]), .SPEED_MODE(srv[5]), .SPEED_CMD_IN(srv[6]),
      .SERVO_ON_IN(srv[7]), .WARNING_OUT_ONE(o1), .WARNING_OUT_TWO(o2), .POS_CMD_OUT(pco),
      .SPEED_LIMITED(sl), .CLEARABLE_ALARM_FLAG(caf), .SPEED_CMD_OUT(sco), .SERVO_ON_STATUS(sos)
   );

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // one-cycle pulses, spaced so the counter sees each one
   task automatic pulse(ref logic s, input int n);
      repeat (n) begin
         s = 1'b1;
         tick(1);
         s = 1'b0;
         tick(1);
      end
   endtask

   // boundary values: one step either side of the load, regen, battery and life thresholds
   task automatic apply(input int w, input logic on);
      case (w)
         0: load_pct = on ? LOAD_WARN_PCT : LOAD_WARN_PCT - 8'h01;
         1: regen_pct = on ? LOAD_WARN_PCT : LOAD_WARN_PCT - 8'h01;
         2: batt_mv = on ? BATT_WARN_MV : BATT_WARN_MV + 12'h001;
         3: fan = on;
         4: if (on) pulse(enc_err, 4); else pulse(enc_ok, 1);
         5: enc_hot = on;
         6: osc = on;
         7: life_left = on ? 16'h00FF : 16'h0100;
         8: scl_alm = on;
         9: if (on) pulse(scl_err, 4); else pulse(scl_ok, 1);
         10: {cspd, est, trq} = {3{on}};
         default: mains = !on;
      endcase
   endtask

   // settle time: fan and mains need their own counts first
   function automatic int wt(input int w);
      return (w == 3) ? FC + 8 : (w == 11) ? 12 * MC + 16 : 8;
   endfunction

   function automatic logic unlim(input int w);
      return w == 2 || w == 7 || ltime == 4'h0;
   endfunction

   task automatic clear_all();
      wclr = 1'b1;
      tick(1);
      wclr = 1'b0;
      tick(6);
   endtask

   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // hang guard, well past the few thousand cycles the run needs
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_of_test();
   end

   initial begin
      void'($urandom(32'hF1978095));
      tick(6);
      rst_b = 1'b1;
      tick(2);
      // status outputs: all-zeros and all-ones first, then random
      for (int n = 0; n < 40; n++) begin
         srv = (n < 2) ? {8{n[0]}} : 8'($urandom);
         tick(1);
         `CHK(pco, srv[0])
         `CHK(sl, srv[1] & srv[2])
         `CHK(caf, srv[3] & srv[4])
         `CHK(sco, srv[5] & srv[6])
         `CHK(sos, srv[7])
      end
      // each warning: raise, hold, release, random mask; boundary first only for slots 4, 9, 10, 11
      for (int w = 0; w < 12; w++) begin
         i1 = 4'(w + 1);
         i2 = 4'h0;
         ltime = (w == 6) ? 4'h0 : LATCH_MIN_S;
         if (w >= 9 || w == 4) begin
            fexp = 16'h0000;
            mtime = 11'h005;
            if (w == 4) pulse(enc_err, 3);
            else if (w == 9) pulse(scl_err, 3);
            else apply(w, 1'b1);
            tick(wt(w));
            `CHK(o1, 1'b0)
            apply(w, 1'b0);
            // let the mains count clear before the time becomes legal
            tick(1);
            fexp = 16'h0002;
            mtime = MAINS_TIME_MIN;
            tick(2);
         end
         apply(w, 1'b1);
         tick(wt(w));
         `CHK(o1, 1'b1)
         `CHK(o2, 1'b1)
         // output two now watches a different, quiet slot
         i2 = 4'((w + 1) % 12 + 1);
         apply(w, 1'b0);
         tick(SC * 3 / 4);
         `CHK(o1, 1'b1)
         `CHK(o2, 1'b0)
         tick(2 * SC + 5);
         `CHK(o1, unlim(w))
         clear_all();
         `CHK(o1, 1'b0)
         `CHK(o2, 1'b0)
         mask = 16'($urandom);
         i2 = i1;
         apply(w, 1'b1);
         tick(wt(w));
         `CHK(o1, !mask[mbit[w]])
         `CHK(o2, !mask[mbit[w]])
         apply(w, 1'b0);
         mask = 16'h0000;
         tick(2 * SC + 8);
         clear_all();
      end
      end_of_test();
   end
endmodule
`default_nettype wire
